// ---- rtl/cpu_ctl_core.sv ----
`timescale 1ns/1ps
`default_nettype none
// sequencing model of the core: 4-state machine cycles, one per step
module cpu_ctl_core
    import cpu_ctl_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    cpu_ctl_if.core bus,
    input wire logic halt_op_i,
    input wire logic int_enable_set_i,
    output logic [15:0] pc_o,
    output logic nmi_taken_o,
    output logic running_o
);
    // one-hot sequencer modes
    typedef enum logic [3:0] {
        ST_RESET = 4'h1,
        ST_RESTART = 4'h2,
        ST_RUN = 4'h4,
        ST_GRANT = 4'h8
    } mode_t;
    // whole core state in one register, so a stopped clock freezes it
    typedef struct packed {
        mode_t mode;
        logic [1:0] tstate;
        logic [1:0] rcnt;
        logic [2:0] rst_sync;
        logic [2:0] req_sync;
        logic [2:0] nmi_sync;
        logic [2:0] int_sync;
        logic nmi_prev;
        logic req_prev;
        logic int_prev;
        logic nmi_pend;
        logic halted;
        logic ie;
        logic [1:0] im;
        logic [7:0] vec;
        logic [6:0] rfsh;
        logic [15:0] pc;
        logic nmi_taken;
    } state_t;
    state_t s;
    state_t next_s;
    logic in_reset;
    logic req_act;
    logic nmi_lvl;
    logic int_act;
    logic last_t;

    // a pin change counts once the second and third stages agree;
    // while they differ the last settled level is kept
    function automatic logic settled(
        input logic [2:0] sync,
        input logic held
    );
        settled = (sync[1] == sync[2]) ? sync[2] : held;
    endfunction

    // settled pin levels; a one-clock glitch never reaches the sequencer
    always_comb
    begin
        in_reset = !settled(s.rst_sync, s.mode != ST_RESET);
        req_act = !settled(s.req_sync, s.req_prev);
        nmi_lvl = settled(s.nmi_sync, s.nmi_prev);
        int_act = !settled(s.int_sync, s.int_prev);
        last_t = (s.tstate == 2'(STATES_PER_CYCLE - 3'h1));
    end

    // next state; a stopped clock simply freezes this register
    always_comb
    begin
        next_s = s;
        next_s.rst_sync = {s.rst_sync[1:0], bus.reset_n};
        next_s.req_sync = {s.req_sync[1:0], bus.bus_request_n};
        next_s.nmi_sync = {s.nmi_sync[1:0], bus.nonmaskable_irq_n};
        next_s.int_sync = {s.int_sync[1:0], bus.maskable_irq_n};
        next_s.nmi_prev = nmi_lvl;
        next_s.req_prev = !req_act;
        next_s.int_prev = !int_act;
        next_s.nmi_taken = 1'b0;
        // enable is a software pulse; taking an interrupt clears it below
        if (int_enable_set_i)
            next_s.ie = 1'b1;
        if (in_reset)
        begin
            // clear core state while reset stays low
            next_s.mode = ST_RESET;
            next_s.pc = RESET_PC;
            next_s.ie = 1'b0;
            next_s.im = RESET_IM;
            next_s.vec = RESET_VEC_BASE;
            next_s.rfsh = RESET_REFRESH;
            next_s.halted = 1'b0;
            next_s.nmi_pend = 1'b0;
            next_s.tstate = 2'h0;
            next_s.rcnt = 2'h0;
        end
        else
        begin
            unique case (s.mode)
                ST_RESET:
                begin
                    // pin has settled high; start the restart count
                    next_s.mode = ST_RESTART;
                    next_s.rcnt = 2'h1;
                end
                ST_RESTART:
                begin
                    // two internal cycles before processing
                    if (s.rcnt >= RESTART_CYCLES)
                        next_s.mode = ST_RUN;
                    else
                        next_s.rcnt = s.rcnt + 2'h1;
                end
                ST_RUN:
                begin
                    next_s.tstate = s.tstate + 2'h1;
                    // refresh counter steps once per machine cycle
                    if (last_t)
                        next_s.rfsh = s.rfsh + 7'h01;
                    if (last_t)
                    begin
                        next_s.tstate = 2'h0;
                        if (req_act)
                            // request wins over nmi; float next edge
                            next_s.mode = ST_GRANT;
                        else if (s.nmi_pend)
                        begin
                            // nmi ignores ie and leaves halt
                            next_s.pc = NMI_VECTOR;
                            next_s.ie = 1'b0;
                            next_s.halted = 1'b0;
                            next_s.nmi_pend = 1'b0;
                            next_s.nmi_taken = 1'b1;
                        end
                        else if (int_act && s.ie)
                        begin
                            // maskable interrupt also exits halt
                            next_s.pc = INT_VECTOR;
                            next_s.ie = 1'b0;
                            next_s.halted = 1'b0;
                        end
                        else if (s.halted)
                            next_s.pc = s.pc; // nop states while halted
                        else if (halt_op_i)
                            next_s.halted = 1'b1;
                        else
                            next_s.pc = s.pc + 16'h0001;
                    end
                end
                ST_GRANT:
                begin
                    // hold off bus until request removed
                    if (!req_act)
                        next_s.mode = ST_RUN;
                end
                default:
                    next_s.mode = ST_RESET;
            endcase
            // edge from the settled level, latched after the case so a
            // new edge in the cycle that takes the old one is kept
            if (s.nmi_prev && !nmi_lvl)
                next_s.nmi_pend = 1'b1;
        end
    end

    // synchronous reset; reset pin stage starts low, other pin stages at their idle levels
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            s <= '0;
            s.mode <= ST_RESET;
            s.rst_sync <= 3'h0;
            s.req_sync <= 3'h7;
            s.nmi_sync <= 3'h7;
            s.int_sync <= 3'h7;
            s.nmi_prev <= 1'b1;
            s.req_prev <= 1'b1;
            s.int_prev <= 1'b1;
        end
        else
            s <= next_s;
    end

    // bus drive; floats in reset and grant
    // limitation: no data phase is modelled, so data always floats
    always_comb
    begin
        bus.addr_o = s.pc;
        bus.addr_oe = (s.mode == ST_RUN) || (s.mode == ST_RESTART);
        bus.data_o = 8'h00;
        bus.data_oe = 1'b0;
        bus.strobe_oe = bus.addr_oe;
        bus.memory_request_n = !((s.mode == ST_RUN) && !last_t);
        bus.read_strobe_n = !((s.mode == ST_RUN) && s.tstate == 2'h1);
        bus.write_strobe_n = 1'b1;
        bus.io_request_n = 1'b1;
        bus.bus_grant_n = !(s.mode == ST_GRANT);
        bus.halt_n = !s.halted;
    end

    // status taps for the test side, straight from the state register
    assign pc_o = s.pc;
    assign nmi_taken_o = s.nmi_taken;
    assign running_o = (s.mode == ST_RUN);
endmodule
`default_nettype wire

// ---- rtl/cpu_ctl_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// pins between the core and an external master / interrupt sources
interface cpu_ctl_if;
    logic [15:0] addr_o;
    logic addr_oe;
    logic [7:0] data_o;
    logic [7:0] data_i;
    logic data_oe;
    logic memory_request_n;
    logic read_strobe_n;
    logic write_strobe_n;
    logic io_request_n;
    logic strobe_oe;
    logic [15:0] ext_addr;
    logic [7:0] ext_data;
    logic ext_data_oe;
    logic ext_strobe_oe;
    logic bus_request_n;
    logic bus_grant_n;
    logic halt_n;
    logic nonmaskable_irq_n;
    logic maskable_irq_n;
    logic reset_n;
    modport core (
        output addr_o, addr_oe, data_o, data_oe, memory_request_n,
        output read_strobe_n, write_strobe_n, io_request_n, strobe_oe,
        output bus_grant_n, halt_n,
        input data_i, bus_request_n, nonmaskable_irq_n, maskable_irq_n,
        input reset_n
    );
    modport master (
        output ext_addr, ext_data, ext_data_oe, ext_strobe_oe,
        output bus_request_n, nonmaskable_irq_n, maskable_irq_n, reset_n,
        input bus_grant_n, halt_n, addr_o, addr_oe, strobe_oe
    );
endinterface
`default_nettype wire

// ---- rtl/cpu_ctl_master.sv ----
`timescale 1ns/1ps
`default_nettype none
// external master plus interrupt and reset source
module cpu_ctl_master
    import cpu_ctl_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    cpu_ctl_if.master bus,
    input wire logic dma_req_i,
    input wire logic [15:0] dma_addr_i,
    input wire logic [7:0] dma_data_i,
    input wire logic nmi_i,
    input wire logic int_i,
    input wire logic sys_reset_i,
    output logic granted_o,
    output logic halted_o
);
    typedef struct packed {
        logic req;
        logic [1:0] rst_cnt;
        logic rst_hold;
        logic nmi_n;
        logic int_n;
        logic [15:0] addr;
        logic [7:0] data;
    } state_t;
    state_t s;
    state_t next_s;

    // requests registered; core synchronises them itself
    always_comb
    begin
        next_s = s;
        next_s.req = dma_req_i;
        next_s.nmi_n = !nmi_i; // falling edge when nmi_i rises
        next_s.int_n = !int_i;
        next_s.addr = dma_addr_i;
        next_s.data = dma_data_i;
        // stretch reset to at least three clocks
        if (sys_reset_i)
        begin
            next_s.rst_hold = 1'b1;
            next_s.rst_cnt = 2'h0;
        end
        else if (s.rst_hold)
        begin
            if (s.rst_cnt >= RESET_MIN_CYCLES - 2'h1)
                next_s.rst_hold = 1'b0;
            else
                next_s.rst_cnt = s.rst_cnt + 2'h1;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            s <= '0;
            s.nmi_n <= 1'b1;
            s.int_n <= 1'b1;
            s.rst_hold <= 1'b1;
        end
        else
            s <= next_s;
    end

    // drive only after grant seen
    always_comb
    begin
        bus.bus_request_n = !s.req;
        bus.nonmaskable_irq_n = s.nmi_n;
        bus.maskable_irq_n = s.int_n;
        bus.reset_n = !s.rst_hold;
        bus.ext_addr = s.addr;
        bus.ext_data = s.data;
        bus.ext_strobe_oe = !bus.bus_grant_n && s.req;
        bus.ext_data_oe = bus.ext_strobe_oe;
    end

    assign granted_o = !bus.bus_grant_n;
    assign halted_o = !bus.halt_n; // clock may be stopped now
endmodule
`default_nettype wire

// ---- rtl/cpu_ctl_pkg.sv ----
// What this block does
// - nmi falls before the instruction's last-state clock
// - sample bus request at last machine state
// - float bus and strobes next edge
// - granted master then drives the bus
// - halt repeats nop states until interrupt
// - halt output low until interrupt; int exits
// - reset held at least three clocks
// - in reset buses float, controls inactive
// - two cycles after reset before processing
// - reset zeroes pc, first fetch at 0000H
// - stopped clock holds all state
// - stop clock low in t4 after halt
// - restored clock resumes where stopped
// - after halt power-down, interrupt or reset exits
// - grant asserted once bus is floating
// - bus request beats nonmaskable interrupt
// - nmi restarts at 0066H regardless of enable
// - reset clears enable, vector, refresh, mode zero
package cpu_ctl_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam logic [15:0] RESET_PC = 16'h0000;
    localparam logic [15:0] NMI_VECTOR = 16'h0066;
    localparam logic [15:0] INT_VECTOR = 16'h0038;
    localparam logic [2:0] STATES_PER_CYCLE = 3'h4;
    localparam logic [1:0] RESTART_CYCLES = 2'h2;
    localparam logic [1:0] RESET_MIN_CYCLES = 2'h3;
    localparam logic [1:0] RESET_IM = 2'h0;
    localparam logic [7:0] RESET_VEC_BASE = 8'h00;
    localparam logic [6:0] RESET_REFRESH = 7'h00;
endpackage

// ---- sim/cpu_bus_halt_reset_control_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, exp, got) begin comparisons++; \
    if ((got) !== (exp)) begin fail_count++; \
    $display("MISMATCH %s exp %0h got %0h", nm, exp, got); end end
module cpu_bus_halt_reset_control_tb
    import cpu_ctl_pkg::*;
;
    logic core_clk_i = 1'b0;
    logic clk_run = 1'b1;
    logic rst_i = 1'b1;
    logic halt_op_i = 1'b0;
    logic ie_set = 1'b0;
    logic dma_req_i = 1'b0;
    logic nmi_i = 1'b0;
    logic int_i = 1'b0;
    logic sys_reset_i = 1'b0;
    logic [15:0] pc_o;
    logic [15:0] pc_hold;
    logic nmi_taken_o, running_o, granted_o, halted_o;
    logic [3:0] flags;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int k;
    cpu_ctl_if bus_if ();
    // core never drives data; idle wire reads as pulled high
    assign bus_if.data_i = bus_if.ext_data_oe ? bus_if.ext_data : 8'hFF;
    assign flags = {nmi_taken_o, halted_o, granted_o, running_o};
    cpu_ctl_core u_cpu_ctl_core (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .bus(bus_if.core), .halt_op_i(halt_op_i), .int_enable_set_i(ie_set),
        .pc_o(pc_o), .nmi_taken_o(nmi_taken_o), .running_o(running_o));
    cpu_ctl_master u_cpu_ctl_master (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .bus(bus_if.master), .dma_req_i(dma_req_i), .dma_addr_i(16'hA5C3),
        .dma_data_i(8'h5A), .nmi_i(nmi_i), .int_i(int_i),
        .sys_reset_i(sys_reset_i), .granted_o(granted_o),
        .halted_o(halted_o));
    cpu_ctl_chk u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .addr_oe(bus_if.addr_oe), .data_oe(bus_if.data_oe),
        .strobe_oe(bus_if.strobe_oe), .ext_strobe_oe(bus_if.ext_strobe_oe),
        .bus_request_n(bus_if.bus_request_n),
        .bus_grant_n(bus_if.bus_grant_n), .halt_n(bus_if.halt_n),
        .nonmaskable_irq_n(bus_if.nonmaskable_irq_n),
        .maskable_irq_n(bus_if.maskable_irq_n), .reset_n(bus_if.reset_n));
    // gated so the clock can be parked for power-down
    initial
    begin
        forever
        begin
            #5;
            if (clk_run)
                core_clk_i = ~core_clk_i;
        end
    end
    task end_sim();
        if (fail_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // hang guard; whole run needs well under a thousand cycles
    always @(posedge core_clk_i)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            fail_count++;
            end_sim();
        end
    end
    task tick(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask
    // bounded poll of one status flag, then compare it
    task wait_on(input int b, input logic v, input string nm);
        k = 0;
        while (flags[b] !== v && k < 300)
        begin
            @(posedge core_clk_i);
            k++;
        end
        `CHECK(nm, v, flags[b])
    endtask
    task pulse_ie();
        ie_set <= 1'b1;
        tick(1);
        ie_set <= 1'b0;
    endtask
    initial
    begin
        tick(16);
        rst_i <= 1'b0;
        wait_on(0, 1'b1, "running");
        `CHECK("pc_reset", RESET_PC, pc_o)
        `CHECK("addr_first", RESET_PC, bus_if.addr_o)
        // bus handover with an nmi queued behind it
        dma_req_i <= 1'b1;
        wait_on(1, 1'b1, "granted");
        `CHECK("addr_oe", 1'b0, bus_if.addr_oe)
        `CHECK("strobe_oe", 1'b0, bus_if.strobe_oe)
        `CHECK("ext_drive", 1'b1, bus_if.ext_strobe_oe)
        `CHECK("ext_addr", 16'hA5C3, bus_if.ext_addr)
        `CHECK("ext_data", 8'h5A, bus_if.data_i)
        nmi_i <= 1'b1;
        tick(2);
        nmi_i <= 1'b0;
        for (int i = 0; i < 30; i++)
        begin
            @(posedge core_clk_i);
            `CHECK("held", 1'b1, granted_o)
            `CHECK("nmi_wait", 1'b0, nmi_taken_o)
        end
        dma_req_i <= 1'b0;
        wait_on(3, 1'b1, "nmi_taken");
        `CHECK("pc_nmi", NMI_VECTOR, pc_o)
        `CHECK("released", 1'b0, granted_o)
        // halt: pc frozen, masked int ignored, clock parked low
        halt_op_i <= 1'b1;
        wait_on(2, 1'b1, "halted");
        halt_op_i <= 1'b0;
        tick(2);
        pc_hold = pc_o;
        int_i <= 1'b1;
        tick(40);
        `CHECK("pc_held", pc_hold, pc_o)
        `CHECK("halt_n", 1'b0, bus_if.halt_n)
        @(negedge core_clk_i) clk_run = 1'b0;
        #498;
        `CHECK("pc_stop", pc_hold, pc_o)
        `CHECK("halt_stop", 1'b0, bus_if.halt_n)
        clk_run = 1'b1;
        tick(4);
        `CHECK("halt_resume", 1'b1, halted_o)
        pulse_ie();
        wait_on(2, 1'b0, "int_exit");
        int_i <= 1'b0;
        // second halt left by nmi
        halt_op_i <= 1'b1;
        wait_on(2, 1'b1, "halted2");
        halt_op_i <= 1'b0;
        nmi_i <= 1'b1;
        tick(2);
        nmi_i <= 1'b0;
        wait_on(2, 1'b0, "nmi_exit");
        // system reset clears enable; later int must not end a halt
        pulse_ie();
        sys_reset_i <= 1'b1;
        tick(1);
        sys_reset_i <= 1'b0;
        wait_on(0, 1'b0, "in_reset");
        `CHECK("memory_request_n_rst", 1'b1, bus_if.memory_request_n)
        `CHECK("rd_rst", 1'b1, bus_if.read_strobe_n)
        `CHECK("addr_oe_rst", 1'b0, bus_if.addr_oe)
        wait_on(0, 1'b1, "restart");
        `CHECK("pc_rst", RESET_PC, pc_o)
        halt_op_i <= 1'b1;
        wait_on(2, 1'b1, "halted3");
        halt_op_i <= 1'b0;
        int_i <= 1'b1;
        tick(40);
        `CHECK("ie_clear", 1'b1, halted_o)
        end_sim();
    end
endmodule
`default_nettype wire

// ---- sim/cpu_ctl_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
// pin-level watcher between core and master
module cpu_ctl_chk (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic addr_oe,
    input wire logic data_oe,
    input wire logic strobe_oe,
    input wire logic ext_strobe_oe,
    input wire logic bus_request_n,
    input wire logic bus_grant_n,
    input wire logic halt_n,
    input wire logic nonmaskable_irq_n,
    input wire logic maskable_irq_n,
    input wire logic reset_n
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    // handover: request passes three sync stages before the grant
    a_grant_bus_float: assert property (
        !bus_grant_n |-> !addr_oe && !data_oe && !strobe_oe)
        else $error("grant while core drives bus");
    a_grant_has_req: assert property (
        $fell(bus_grant_n) |-> !$past(bus_request_n, 3))
        else $error("grant without request");
    a_req_answered: assert property (
        $fell(bus_request_n) && reset_n |-> ##[1:16] !bus_grant_n)
        else $error("request not granted");
    a_grant_holds: assert property (
        !bus_grant_n && !bus_request_n && reset_n |=> !bus_grant_n)
        else $error("grant dropped early");
    a_grant_release: assert property (
        $rose(bus_request_n) && !bus_grant_n |-> ##[2:6] bus_grant_n)
        else $error("grant not released");
    a_no_contention: assert property (
        ext_strobe_oe |-> !bus_grant_n && !addr_oe && !strobe_oe)
        else $error("master drives ungranted bus");
    // reset: held long enough, floats bus, then a short restart gap
    a_reset_width: assert property (
        $fell(reset_n) |-> !reset_n [*3])
        else $error("reset too short");
    a_reset_float: assert property (
        !$past(reset_n, 3) && !$past(reset_n, 4) |-> !addr_oe && !data_oe
            && !strobe_oe && bus_grant_n && halt_n)
        else $error("bus driven in reset");
    a_restart_gap: assert property (
        $rose(reset_n) && bus_request_n |-> ##1 !addr_oe [*3] ##1 addr_oe)
        else $error("restart timing wrong");
    // halt left by an interrupt or reset; quiet inputs keep it
    a_nmi_ends_halt: assert property (
        $fell(nonmaskable_irq_n) && !halt_n && bus_request_n
            |-> ##[1:16] halt_n)
        else $error("nmi did not end halt");
    a_halt_stays: assert property (
        (nonmaskable_irq_n && maskable_irq_n && reset_n) [*8] ##0 !halt_n
            |=> !halt_n)
        else $error("halt left without cause");
endmodule
`default_nettype wire
